//--- tkd_dispenser_model.sv
`timescale 1ns/1ps
`default_nettype none
module tkd_dispenser_model
(
    input wire logic mclk,
    input wire logic motor_enable,
    input wire logic jam,
    output logic ticket_sense
);
    logic [7:0] feed = 8'h00;
    always @(posedge mclk)
        feed <= (motor_enable && !jam) ? feed + 8'h01 : 8'h00;
    // beam blocked for a few cycles once feeding, pulled low when clear
    assign ticket_sense = feed > 8'h04 && feed < 8'h0C;
endmodule : tkd_dispenser_model
`default_nettype wire

//--- tkd_pkg.sv
package tkd_pkg;
    localparam int unsigned TKD_CLK_HZ = 40000000;
    // dispense timeout, in milliseconds
    localparam int unsigned TKD_TIMEOUT_MS = 333;
    localparam int unsigned TKD_TIMEOUT_CYC = (TKD_CLK_HZ / 1000) * TKD_TIMEOUT_MS;
    localparam int unsigned TKD_TIMEOUT_W = 24;
    // glitch filter settle time, in microseconds
    localparam int unsigned TKD_FILT_US = 100;
    localparam int unsigned TKD_FILT_CYC = (TKD_CLK_HZ / 1000000) * TKD_FILT_US;
    localparam int unsigned TKD_FILT_W = 13;
    localparam int unsigned TKD_COUNT_W = 32;
    localparam logic [TKD_COUNT_W-1:0] TKD_COUNT_RST = 32'h00000000;
    typedef enum logic [1:0] {TKD_IDLE, TKD_WAIT_HIGH, TKD_WAIT_LOW} tkd_state_t;
endpackage : tkd_pkg

//--- tkd_sense_filter.sv
`timescale 1ns/1ps
`default_nettype none
module tkd_sense_filter
    import tkd_pkg::*;
#(
    parameter logic [TKD_FILT_W-1:0] FILT_CYC = TKD_FILT_W'(TKD_FILT_CYC)
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sense_pin,
    output logic sense_level
);
    logic sync_a;
    logic sync_b;
    logic [TKD_FILT_W-1:0] cnt;
    logic [TKD_FILT_W-1:0] next_cnt;
    logic next_level;

    // level changes only after the synced input holds a new value for FILT_CYC cycles
    always_comb
    begin
        next_cnt = '0;
        next_level = sense_level;
        if (sync_b != sense_level)
        begin
            if (cnt >= FILT_CYC - 1'b1)
                next_level = sync_b;
            else
                next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt <= '0;
            sense_level <= 1'b0;
        end
        else
        begin
            sync_a <= sense_pin; // [RULE_09]
            sync_b <= sync_a;
            cnt <= next_cnt;
            sense_level <= next_level; // [RULE_09]
        end
    end
endmodule : tkd_sense_filter
`default_nettype wire

//--- tkd_ticket_dispenser_driver.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// (RULE_01) motor output high only while the motor should run, otherwise low
// (RULE_02) sensor low means clear, high means a ticket blocks it
// (RULE_03) on request, motor runs until sensor goes high then low again
// (RULE_04) no full pulse within about a third second: stop, flag empty or jammed
// (RULE_05) dispenser gives an open-collector sense signal, high when blocked
// (RULE_06) dispenser runs its motor while the motor input is high
// (RULE_07) no requests issued unless ticket dispensing is enabled; default off
// (RULE_08) keep a running count of tickets dispensed for audits
// (RULE_09) sensor synchronised and filtered; timeout counter sets a fault flag
module tkd_ticket_dispenser_driver
    import tkd_pkg::*;
#(
    parameter logic [TKD_TIMEOUT_W-1:0] TIMEOUT_CYC = TKD_TIMEOUT_W'(TKD_TIMEOUT_CYC),
    parameter logic [TKD_FILT_W-1:0] FILT_CYC = TKD_FILT_W'(TKD_FILT_CYC)
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tickets_enable,
    input wire logic dispense_req,
    output logic dispense_ready,
    output logic dispense_done,
    output logic dispense_fault,
    input wire logic fault_clear,
    output logic fault,
    output logic [TKD_COUNT_W-1:0] tickets_dispensed,
    input wire logic ticket_sense,
    output logic motor_enable
);
    tkd_state_t state;
    tkd_state_t next_state;
    logic [TKD_TIMEOUT_W-1:0] timer;
    logic [TKD_TIMEOUT_W-1:0] next_timer;
    logic next_motor;
    logic next_done;
    logic next_fail;
    logic next_fault;
    logic [TKD_COUNT_W-1:0] next_count;
    logic blocked;
    logic timed_out;
    logic take;
    logic passed;
    logic expired;

    // true while a ticket is in flight and the motor must run
    function automatic logic tkd_busy(input tkd_state_t st);
        return (st == TKD_WAIT_HIGH) || (st == TKD_WAIT_LOW);
    endfunction : tkd_busy

    tkd_sense_filter #(
        .FILT_CYC(FILT_CYC)
    ) u_filter (
        .mclk(mclk),
        .rst(rst),
        .sense_pin(ticket_sense),
        .sense_level(blocked) // [RULE_02]
    );

    // requests are accepted only with dispensing enabled
    assign dispense_ready = (state == TKD_IDLE) && tickets_enable; // [RULE_07]
    assign take = dispense_req && dispense_ready; // [RULE_07]
    assign timed_out = (timer >= TIMEOUT_CYC - 1'b1);
    // completed high-then-low pulse; one ending on the timeout cycle still counts
    assign passed = (state == TKD_WAIT_LOW) && !blocked; // [RULE_03]
    assign expired = tkd_busy(state) && timed_out && !passed; // [RULE_04]

    // sequencer: idle, wait for the beam to block, wait for it to clear
    always_comb
    begin
        next_state = state;
        unique case (state)
            TKD_IDLE:
            begin
                if (take)
                begin
                    next_state = TKD_WAIT_HIGH; // [RULE_03]
                end
            end
            TKD_WAIT_HIGH:
            begin
                if (expired)
                begin
                    next_state = TKD_IDLE; // [RULE_04]
                end
                else if (blocked)
                begin
                    next_state = TKD_WAIT_LOW; // [RULE_02]
                end
            end
            TKD_WAIT_LOW:
            begin
                if (passed || expired)
                begin
                    next_state = TKD_IDLE; // [RULE_03]
                end
            end
            default:
            begin
                next_state = TKD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= TKD_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // counts motor-on cycles toward the dispense timeout
    always_comb
    begin
        next_timer = '0;
        if (tkd_busy(state) && !passed && !expired)
        begin
            next_timer = timer + 1'b1; // [RULE_09]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timer <= '0;
        end
        else
        begin
            timer <= next_timer;
        end
    end

    // illegal state codes leave the motor off
    always_comb
    begin
        next_motor = 1'b0;
        next_done = 1'b0;
        next_fail = 1'b0;
        if (state == TKD_IDLE)
        begin
            next_motor = take; // [RULE_03]
        end
        else if (tkd_busy(state))
        begin
            next_motor = !(passed || expired); // [RULE_01]
            next_done = passed; // [RULE_03]
            next_fail = expired; // [RULE_04]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            motor_enable <= 1'b0;
            dispense_done <= 1'b0;
            dispense_fault <= 1'b0;
        end
        else
        begin
            motor_enable <= next_motor;
            dispense_done <= next_done;
            dispense_fault <= next_fail;
        end
    end

    // sticky fault: a timeout in the same cycle as a clear wins
    always_comb
    begin
        next_fault = fault;
        if (fault_clear)
        begin
            next_fault = 1'b0;
        end
        if (expired)
        begin
            next_fault = 1'b1; // [RULE_09]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fault <= 1'b0;
        end
        else
        begin
            fault <= next_fault;
        end
    end

    // audit total of good tickets, wraps silently
    always_comb
    begin
        next_count = tickets_dispensed;
        if (passed)
        begin
            next_count = tickets_dispensed + 1'b1; // [RULE_08]
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tickets_dispensed <= TKD_COUNT_RST;
        end
        else
        begin
            tickets_dispensed <= next_count;
        end
    end
endmodule : tkd_ticket_dispenser_driver
`default_nettype wire

//--- tkd_ticket_dispenser_driver_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tkd_ticket_dispenser_driver_bench;
    import tkd_pkg::*;
    localparam logic [TKD_TIMEOUT_W-1:0] TO = 24'h0000C8;
    logic mclk = 0, rst = 1, tickets_enable = 0, dispense_req = 0, fault_clear = 0, jam = 0;
    logic dispense_ready, dispense_done, dispense_fault, fault, motor_enable;
    logic [TKD_COUNT_W-1:0] tickets_dispensed;
    wire ticket_sense;
    int n_checks = 0, n_mismatch = 0, n;
    always #12.5 mclk = ~mclk;
    tkd_ticket_dispenser_driver #(.TIMEOUT_CYC(TO), .FILT_CYC(13'h0003))
        tkd_ticket_dispenser_driver_inst (.*);
    tkd_dispenser_model tkd_dispenser_model_inst (.*);
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick
    task automatic ask();
        dispense_req = 1;
        tick();
        dispense_req = 0;
        n = 0;
    endtask : ask
    task automatic wait_end();
        while ((dispense_done | dispense_fault) !== 1'b1)
        begin
            tick();
            n++;
            if (n > 5000)
            begin
                n_mismatch++;
                report_and_stop();
            end
        end
    endtask : wait_end
    task automatic t_disabled();
        ask();
        repeat (8) tick();
        `CHK("motor", 1'b0, motor_enable)
        `CHK("ready", 1'b0, dispense_ready)
        $display("t_disabled end");
    endtask : t_disabled
    task automatic t_tickets();
        tickets_enable = 1;
        ask();
        `CHK("motor", 1'b1, motor_enable)
        `CHK("ready", 1'b0, dispense_ready)
        wait_end();
        `CHK("done", 1'b1, dispense_done)
        `CHK("ready", 1'b1, dispense_ready)
        `CHK("count", 32'h00000001, tickets_dispensed)
        ask();
        wait_end();
        `CHK("count", 32'h00000002, tickets_dispensed)
        $display("t_tickets end");
    endtask : t_tickets
    task automatic t_jam();
        jam = 1;
        ask();
        wait_end();
        `CHK("timeout", int'(TO), n)
        `CHK("motor", 1'b0, motor_enable)
        tick();
        `CHK("fault", 1'b1, fault)
        fault_clear = 1;
        tick();
        fault_clear = 0;
        `CHK("fault", 1'b0, fault)
        `CHK("count", 32'h00000002, tickets_dispensed)
        $display("t_jam end");
    endtask : t_jam
    initial
    begin
        repeat (16) tick();
        rst = 0;
        t_disabled();
        t_tickets();
        t_jam();
        report_and_stop();
    end
endmodule : tkd_ticket_dispenser_driver_bench
`default_nettype wire

//--- tkd_ticket_dispenser_driver_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tkd_ticket_dispenser_driver_monitor
    import tkd_pkg::*;
#(
    parameter logic [TKD_TIMEOUT_W-1:0] TIMEOUT_CYC = TKD_TIMEOUT_W'(TKD_TIMEOUT_CYC)
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic dispense_req,
    input wire logic dispense_ready,
    input wire logic dispense_done,
    input wire logic dispense_fault,
    input wire logic fault_clear,
    input wire logic fault,
    input wire logic [TKD_COUNT_W-1:0] tickets_dispensed,
    input wire logic motor_enable
);
    logic [TKD_TIMEOUT_W-1:0] on_cyc;
    // cycles the motor has been sampled high
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            on_cyc <= '0;
        else if (!motor_enable)
            on_cyc <= '0;
        else
            on_cyc <= on_cyc + 1'b1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_take;
        dispense_req && dispense_ready;
    endsequence
    a_take_motor: assert property (s_take |=> motor_enable) else $error("no start");
    a_start_cause: assert property ($rose(motor_enable) |-> $past(dispense_req && dispense_ready))
        else $error("start uncaused");
    a_drop_end: assert property ($fell(motor_enable) |-> dispense_done ^ dispense_fault)
        else $error("bad stop");
    a_count_up: assert property (dispense_done |-> tickets_dispensed ==
        $past(tickets_dispensed) + 1'b1) else $error("no count");
    a_count_hold: assert property (!dispense_done |-> $stable(tickets_dispensed))
        else $error("count moved");
    a_timeout_at: assert property (dispense_fault |-> on_cyc == TIMEOUT_CYC && !motor_enable)
        else $error("timeout late");
    a_motor_max: assert property (on_cyc <= TIMEOUT_CYC) else $error("motor overrun");
    a_fault_hold: assert property (fault && !fault_clear |=> fault) else $error("fault lost");
endmodule : tkd_ticket_dispenser_driver_monitor
bind tkd_ticket_dispenser_driver tkd_ticket_dispenser_driver_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC))
    tkd_ticket_dispenser_driver_monitor_inst (.*);
`default_nettype wire
